// ===== window_watchdog_timer.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"

module window_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int SLOW_DIV = `WDT_SLOW_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Option byte from flash, and standby state
    input wire logic [7:0] option_byte,
    input wire logic standby,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Watchdog and oscillator outputs
    output logic internal_reset_q,
    output logic slow_osc_running,
    output logic fast_osc_stop
);

    // Parameter limits that the logic can serve; the divider is 16 bits wide
    if (ADDR_W < 16 || ADDR_W > 32) begin : g_addr_w_check
        $error("ADDR_W must be 16..32");
    end
    if (SLOW_DIV < 2 || SLOW_DIV > 65536) begin : g_slow_div_check
        $error("SLOW_DIV must be 2..65536");
    end

    localparam int CW = 17;

    // Last count before overflow for an overflow code
    function automatic logic [CW-1:0] ovf_last(input logic [2:0] sel);
        logic [CW:0] period;
        period = (CW+1)'(1) << (`WDT_OVF_EXP_BASE + sel);
        return CW'(period - (CW+1)'(1));
    endfunction

    // First count of the open window: closed part of the period
    function automatic logic [CW-1:0] open_start(input logic [2:0] sel,
                                                 input logic [1:0] win);
        logic [CW:0] quarter;
        quarter = (CW+1)'(1) << (`WDT_OVF_EXP_BASE + sel - 2);
        return CW'(quarter * (CW+1)'(2'h3 - win));
    endfunction

    option_cfg_t cfg_q;
    logic loaded_q;
    osc_mode_t mode_q;
    logic [15:0] div_q;
    logic [CW-1:0] count_q;
    logic first_q;
    logic aw_hold_q, w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic bvalid_q, rvalid_q;
    logic [31:0] rdata_q;

    logic [2:0] ovf_sel;
    logic [1:0] win_sel;
    logic active, stop_allowed, tick, at_last, wr_fire;
    logic restart_evt, overflow, bad_restart, good_restart;
    logic [CW-1:0] last_cnt, open_cnt;

    // Option fields latched once after reset release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= '0;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            cfg_q <= option_cfg_t'({1'b0, option_byte[6:0]});
            loaded_q <= 1'b1;
        end
    end

    // Decoded option fields
    assign ovf_sel = {cfg_q.overflow_select_bit2, cfg_q.overflow_select_bit1,
                      cfg_q.overflow_select_bit0};
    assign win_sel = {cfg_q.open_window_select_hi, cfg_q.open_window_select_lo};
    assign last_cnt = ovf_last(ovf_sel);
    assign open_cnt = open_start(ovf_sel, win_sel);
    assign active = loaded_q && cfg_q.watchdog_enable_option;

    // Slow and fast oscillator gating
    assign stop_allowed = loaded_q && !cfg_q.slow_osc_stop_permit;
    assign slow_osc_running =
        !(stop_allowed && (mode_q.slow_osc_stop_request || standby));
    assign fast_osc_stop = mode_q.fast_osc_stop_request;

    // Slow clock tick; divider frozen while the oscillator is stopped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (slow_osc_running) begin
            div_q <= (div_q == 16'(SLOW_DIV - 1)) ? '0 : div_q + 16'h0001;
        end
    end
    assign tick = slow_osc_running && (div_q == 16'(SLOW_DIV - 1));

    // Restart detection and outcome
    assign at_last = (count_q == last_cnt);
    assign overflow = active && tick && at_last;
    assign bad_restart = active && restart_evt && !first_q
                         && (count_q < open_cnt);
    assign good_restart = active && restart_evt && !bad_restart && !overflow;

    // Internal reset pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            internal_reset_q <= 1'b0;
        end else begin
            internal_reset_q <= overflow || bad_restart;
        end
    end

    // Watchdog counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (!active || overflow || bad_restart) begin
            count_q <= '0;
        end else if (good_restart) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + CW'(1);
        end
    end

    // First-restart exemption flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_q <= 1'b1;
        end else if (overflow || bad_restart) begin
            first_q <= 1'b1;
        end else if (good_restart) begin
            first_q <= 1'b0;
        end
    end

    // Write channel acceptance
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign restart_evt = wr_fire && (awaddr_q == ADDR_W'(`WDT_RESTART_ADDR));

    // Address and data holding
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Oscillator mode register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= osc_mode_t'(3'h4);
        end else if (wr_fire && wstrb_q[0] && (awaddr_q == ADDR_W'(`WDT_OSC_MODE_ADDR))) begin
            mode_q.slow_osc_stop_request <= wdata_q[`WDT_MODE_SLOW_STOP];
            mode_q.fast_osc_stop_request <= wdata_q[`WDT_MODE_FAST_STOP];
            mode_q.fast_osc_status <= !wdata_q[`WDT_MODE_FAST_STOP];
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `WDT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q == ADDR_W'(`WDT_OSC_MODE_ADDR)
                        || awaddr_q == ADDR_W'(`WDT_RESTART_ADDR)
                        || awaddr_q == ADDR_W'(`WDT_STATUS_ADDR))
                       ? `WDT_RESP_OKAY : `WDT_RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Read channel
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `WDT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= `WDT_RESP_OKAY;
            rdata_q <= '0;
            if (s_axi_araddr == ADDR_W'(`WDT_OSC_MODE_ADDR)) begin
                rdata_q[`WDT_MODE_FAST_STATUS] <= mode_q.fast_osc_status;
                rdata_q[`WDT_MODE_SLOW_STOP] <= mode_q.slow_osc_stop_request;
                rdata_q[`WDT_MODE_FAST_STOP] <= mode_q.fast_osc_stop_request;
            end else if (s_axi_araddr == ADDR_W'(`WDT_STATUS_ADDR)) begin
                rdata_q[CW-1:0] <= count_q;
                rdata_q[`WDT_ST_FIRST] <= first_q;
                rdata_q[`WDT_ST_CFG_LSB +: 8] <= cfg_q;
            end else if (s_axi_araddr != ADDR_W'(`WDT_RESTART_ADDR)) begin
                rresp_q <= `WDT_RESP_DECERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence closed_try_s;
        active && restart_evt && !first_q && count_q < open_cnt;
    endsequence
    sequence first_try_s;
        active && restart_evt && first_q && !overflow;
    endsequence
    sequence reset_then_clear_s;
        internal_reset_q && count_q == '0 && first_q;
    endsequence

    overflow_reset_a: assert property (
        active && tick && count_q == last_cnt |=> reset_then_clear_s)
        else $error("overflow did not raise internal reset");
    closed_restart_a: assert property (
        closed_try_s |=> reset_then_clear_s)
        else $error("closed-window restart did not reset");
    first_restart_a: assert property (
        first_try_s |=> !internal_reset_q && count_q == '0 && !first_q)
        else $error("first restart was not accepted");
    open_restart_a: assert property (
        active && restart_evt && !first_q && count_q >= open_cnt && !overflow
        |=> !internal_reset_q && count_q == '0)
        else $error("open-window restart mishandled");
    hold_count_a: assert property (
        !slow_osc_running && !restart_evt && active |=> $stable(count_q))
        else $error("count moved while oscillator stopped");
    standby_stop_a: assert property (
        stop_allowed && (standby || mode_q.slow_osc_stop_request)
        |-> !slow_osc_running ##1 $stable(div_q))
        else $error("oscillator runs despite permitted stop");
    locked_run_a: assert property (
        loaded_q && cfg_q.slow_osc_stop_permit |-> slow_osc_running)
        else $error("locked oscillator was stopped");
    disabled_idle_a: assert property (
        loaded_q && !cfg_q.watchdog_enable_option
        |=> count_q == '0 && !internal_reset_q)
        else $error("disabled watchdog counted or reset");
    cfg_locked_a: assert property (
        loaded_q |=> $stable(cfg_q) && !cfg_q.fixed_zero)
        else $error("option fields changed while running");
    mode_reset_a: assert property (
        $rose(rst_n) |-> mode_q == osc_mode_t'(3'h4))
        else $error("mode register reset value wrong");

endmodule // window_watchdog_timer

// ===== wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
// Register byte addresses
`define WDT_OSC_MODE_ADDR 16'hFFA0
`define WDT_RESTART_ADDR 16'hFFA4
`define WDT_STATUS_ADDR 16'hFFA8
// Reset value of the oscillator mode register
`define WDT_OSC_MODE_RESET 8'h80
// Oscillator mode register fields
`define WDT_MODE_FAST_STATUS 7
`define WDT_MODE_SLOW_STOP 1
`define WDT_MODE_FAST_STOP 0
// Status register fields
`define WDT_ST_FIRST 20
`define WDT_ST_CFG_LSB 24
// Overflow exponent of code 000
`define WDT_OVF_EXP_BASE 10
// Shortest overflow time and main clock period
`define WDT_MIN_OVF_NS 3880000
`define WDT_CLK_PERIOD_NS 4
// Main clock cycles per slow oscillator cycle
`define WDT_SLOW_DIV ((`WDT_MIN_OVF_NS / `WDT_CLK_PERIOD_NS) / 1024)
// AXI responses
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_DECERR 2'h3
`endif

// ===== wdt_pkg.sv
package wdt_pkg;
    // Option byte, bit 7 down to bit 0
    typedef struct packed {
        logic fixed_zero;
        logic open_window_select_hi;
        logic open_window_select_lo;
        logic watchdog_enable_option;
        logic overflow_select_bit2;
        logic overflow_select_bit1;
        logic overflow_select_bit0;
        logic slow_osc_stop_permit; // 1 = stop locked out
    } option_cfg_t;

    // Oscillator mode register contents
    typedef struct packed {
        logic fast_osc_status;
        logic slow_osc_stop_request;
        logic fast_osc_stop_request;
    } osc_mode_t;
endpackage

// ===== cpu_software_model.sv
`timescale 1ns/1ps
// Software side: one AXI4-Lite access at a time, main loop only
module cpu_software_model (
    // Clock
    input wire logic clk,
    // Write channels
    output logic [15:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [15:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    int bad_resp = 0;
    // Idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // Word write; the caller picks the restart moment
    task automatic wr(input logic [15:0] a, input logic [31:0] dat);
        @(posedge clk);
        awaddr <= a;
        wdata <= dat;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        // Every register this model writes is mapped
        if (bresp !== 2'h0) bad_resp++;
        bready <= 1'b0;
    endtask
    // Word read, returns data and response
    task automatic rd(input logic [15:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        dat = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
endmodule // cpu_software_model

// ===== window_watchdog_timer_tb_top.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR %0t mismatch %0h vs %0h", $time, (a), (b)); end end
module window_watchdog_timer_tb_top;
    import wdt_pkg::*;
    localparam int SD = 2;
    typedef struct {logic [7:0] opt; int ticks; logic hit;} row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] option_byte = 8'h10;
    logic standby = 1'b0;
    logic [15:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic internal_reset_q, slow_osc_running, fast_osc_stop;
    logic [16:0] c1, c2;
    int miscompares = 0;
    int n_tests = 0;
    int rst_seen = 0;
    int base;
    // Option, slow ticks between restarts, internal reset expected
    row_t rows[14] = '{'{8'h10, 760, 1'b1}, '{8'h10, 776, 1'b0}, '{8'h30, 504, 1'b1},
        '{8'h30, 520, 1'b0}, '{8'h50, 248, 1'b1}, '{8'h50, 264, 1'b0}, '{8'h70, 0, 1'b0},
        '{8'h00, 1100, 1'b0}, '{8'h10, 1040, 1'b1}, '{8'h12, 2040, 1'b0},
        '{8'h12, 2056, 1'b1}, '{8'h14, 4088, 1'b0}, '{8'h14, 4104, 1'b1},
        '{8'h76, 8184, 1'b0}};

    window_watchdog_timer #(.ADDR_W(16), .SLOW_DIV(SD)) window_watchdog_timer_inst (
        .clk(clk), .rst_n(rst_n), .option_byte(option_byte), .standby(standby),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .internal_reset_q(internal_reset_q), .slow_osc_running(slow_osc_running),
        .fast_osc_stop(fast_osc_stop));
    cpu_software_model sw_inst (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    // Count internal reset pulses
    always @(posedge clk) begin
        if (internal_reset_q === 1'b1) rst_seen <= rst_seen + 1;
    end
    task automatic final_report();
        if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Reset with a new option byte; one value stands for both flash copies
    task automatic do_reset(input logic [7:0] opt);
        @(posedge clk);
        rst_n <= 1'b0;
        option_byte <= opt;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic count(output logic [16:0] c);
        sw_inst.rd(`WDT_STATUS_ADDR, d, r);
        c = d[16:0];
    endtask
    // Stop the oscillator by request or standby, then let it run again
    task automatic freeze(input logic [7:0] opt, input logic sb, input logic held);
        do_reset(opt);
        sw_inst.wr(`WDT_RESTART_ADDR, 32'h0);
        repeat (20) @(posedge clk);
        if (sb) standby <= 1'b1;
        else sw_inst.wr(`WDT_OSC_MODE_ADDR, 32'h2);
        repeat (4) @(posedge clk);
        count(c1);
        repeat (50) @(posedge clk);
        count(c2);
        `CHK(c1 === c2, held)
        `CHK(slow_osc_running, !held)
        standby <= 1'b0;
        sw_inst.wr(`WDT_OSC_MODE_ADDR, 32'h0);
        repeat (50) @(posedge clk);
        count(c1);
        `CHK(c1 > c2 && c2 != 0, 1'b1)
    endtask

    // Main sequence
    initial begin
        do_reset(8'h90);
        sw_inst.rd(`WDT_OSC_MODE_ADDR, d, r);
        `CHK(d[7:0], `WDT_OSC_MODE_RESET)
        sw_inst.rd(`WDT_STATUS_ADDR, d, r);
        `CHK(d[31:24], 8'h10)
        `CHK(d[`WDT_ST_FIRST], 1'b1)
        option_byte <= 8'h00;
        repeat (4) @(posedge clk);
        sw_inst.rd(`WDT_STATUS_ADDR, d, r);
        `CHK(d[31:24], 8'h10)
        sw_inst.rd(16'h0010, d, r);
        `CHK(r, `WDT_RESP_DECERR)
        sw_inst.wr(`WDT_OSC_MODE_ADDR, 32'h1);
        `CHK(fast_osc_stop, 1'b1)
        sw_inst.rd(`WDT_OSC_MODE_ADDR, d, r);
        `CHK(d[7:0], 8'h01)
        // First restart exempt, second one judged by the window unless the counter overflowed first
        foreach (rows[i]) begin
            do_reset(rows[i].opt);
            base = rst_seen;
            sw_inst.wr(`WDT_RESTART_ADDR, 32'h0);
            repeat (rows[i].ticks * SD) @(posedge clk);
            sw_inst.wr(`WDT_RESTART_ADDR, 32'h0);
            repeat (10) @(posedge clk);
            `CHK(rst_seen - base, rows[i].hit)
        end
        freeze(8'h10, 1'b0, 1'b1);
        freeze(8'h10, 1'b1, 1'b1);
        freeze(8'h11, 1'b0, 1'b0);
        freeze(8'h11, 1'b1, 1'b0);
        `CHK(sw_inst.bad_resp, 0)
        final_report();
    end
    // Watchdog against a hang: about 75,000 cycles, the tests need some 53,000
    initial begin
        #300000;
        miscompares++;
        final_report();
    end
endmodule // window_watchdog_timer_tb_top
